// *** fdsc_decoder.sv ***
// Command decoder and function register file of the flash LED driver.
// Assumes an I2C slave presents each completed write as one-cycle valid, address and data.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Writing the shutdown address enters shutdown and forces all LED drivers off.
// - Shutdown keeps every configuration register value for later use.
// - In shutdown the rail is not regulated and the reservoir switch opens.
// - Reservoir mid-point bias stays on in shutdown until output falls below 2 V.
// - Any data byte written to the shutdown address triggers shutdown.
// - Output voltage and recharge current selectors take three-bit codes.
// - Thermistor bias, indicator, both flash and torch currents take six-bit codes.
// - Thermistor reference takes five bits; flash time-out takes seven bits.
// - Pulse widths, delays and photo reference take full eight-bit codes.
// - Writing one to bit seven of the second configuration clears all registers.
module fdsc_decoder
  import fdsc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire fdsc_wr_t wr_in,
  input wire logic vout_below_2v,
  output logic shutdown_o,
  output logic led_drive_en_o,
  output logic rail_reg_en_o,
  output logic reservoir_sw_o,
  output logic bias_en_o,
  output logic [FDSC_NREG*8-1:0] regs_o
);
  // Register index for each mapped address; 0 means unmapped
  // Reserved and status addresses fall to 0 and store nothing, though a write to one still wakes the device
  function automatic logic [4:0] reg_index(input logic [7:0] a);
    unique case (a)
      FDSC_ADDR_CFG0: reg_index = 5'h01;
      FDSC_ADDR_CFG1: reg_index = 5'h02;
      FDSC_ADDR_FLASH1: reg_index = 5'h03;
      FDSC_ADDR_FLASH2: reg_index = 5'h04;
      FDSC_ADDR_TORCH: reg_index = 5'h05;
      FDSC_ADDR_DLY1: reg_index = 5'h06;
      FDSC_ADDR_DLY2: reg_index = 5'h07;
      FDSC_ADDR_WID1: reg_index = 5'h08;
      FDSC_ADDR_WID2: reg_index = 5'h09;
      FDSC_ADDR_PHREF: reg_index = 5'h0A;
      FDSC_ADDR_VOUT: reg_index = 5'h0B;
      FDSC_ADDR_IND: reg_index = 5'h0C;
      FDSC_ADDR_NTCREF: reg_index = 5'h0D;
      FDSC_ADDR_NTCBIAS: reg_index = 5'h0E;
      FDSC_ADDR_RECHG: reg_index = 5'h0F;
      FDSC_ADDR_TOUT: reg_index = 5'h10;
      default: reg_index = 5'h00;
    endcase
  endfunction

  // Code-width mask per slot, slot k holds index k+1
  // Bits above a setting's width are dropped before they reach the store
  function automatic logic [7:0] slot_mask(input int k);
    logic [7:0] m;
    m = FDSC_MASK8;
    case (k)
      2, 3, 4, 11, 13: m = FDSC_MASK6;
      10, 14: m = FDSC_MASK3;
      12: m = FDSC_MASK5;
      15: m = FDSC_MASK7;
      default: m = FDSC_MASK8;
    endcase
    slot_mask = m;
  endfunction

  fdsc_state_t state_ff;
  fdsc_state_t nxt_state;
  logic [7:0] regs_ff [FDSC_NREG];
  logic shdn_cmd_wr;
  logic clear_all;
  logic [4:0] widx;
  logic [7:0] cfg1_view;

  // Write decode; the data byte plays no part in recognising the shutdown command
  assign widx = reg_index(wr_in.addr);
  assign shdn_cmd_wr = wr_in.valid && (wr_in.addr == FDSC_ADDR_SHUTDOWN);
  // Second configuration as it will stand after this edge, so the controls never lag a write
  assign cfg1_view = (wr_in.valid && widx == 5'h02) ? wr_in.data : regs_ff[1];
  assign clear_all = wr_in.valid && (wr_in.addr == FDSC_ADDR_CFG1) && wr_in.data[FDSC_CFG1_CLEAR_BIT];

  // Register slots; shutdown does not touch them
  // Each slot has a second flop for its output copy, so regs_o leaves a flip-flop directly
  genvar g;
  generate
    for (g = 0; g < FDSC_NREG; g++) begin : g_reg
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          regs_ff[g] <= FDSC_REG_RESET;
        end else if (clear_all) begin
          regs_ff[g] <= FDSC_REG_RESET;
        end else if (wr_in.valid && widx == 5'(g + 1)) begin
          regs_ff[g] <= wr_in.data & slot_mask(g);
        end
      end
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          regs_o[g*8 +: 8] <= FDSC_REG_RESET;
        end else if (clear_all) begin
          regs_o[g*8 +: 8] <= FDSC_REG_RESET;
        end else if (wr_in.valid && widx == 5'(g + 1)) begin
          regs_o[g*8 +: 8] <= wr_in.data & slot_mask(g);
        end
      end
      // Each slot: output copy matches the store, no bit above the code width, cleared by the reset bit
      slot_mirror_a: assert property (@(posedge mclk) disable iff (!rst_n)
        regs_o[g*8 +: 8] == regs_ff[g])
        else $error("Register output differs from stored value");
      slot_width_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (regs_ff[g] & ~slot_mask(g)) == 8'h00)
        else $error("Bit above code width is set");
      slot_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
        clear_all |=> regs_ff[g] == FDSC_REG_RESET)
        else $error("Register survived the clear bit");
    end
  endgenerate

  // Power state: any non-shutdown write wakes the device
  // Waking keeps the stored settings, so the device resumes as programmed
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      FDSC_ACTIVE: if (shdn_cmd_wr) nxt_state = FDSC_SHDN_BIAS;
      FDSC_SHDN_BIAS: begin
        if (wr_in.valid && !shdn_cmd_wr) nxt_state = FDSC_ACTIVE;
        else if (vout_below_2v) nxt_state = FDSC_SHDN;
      end
      FDSC_SHDN: if (wr_in.valid && !shdn_cmd_wr) nxt_state = FDSC_ACTIVE;
      default: nxt_state = FDSC_ACTIVE;
    endcase
  end

  // State register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) state_ff <= FDSC_ACTIVE;
    else state_ff <= nxt_state;
  end

  // Analog control outputs, registered from next state
  // Taking the next state lets every control move on the same edge as the state itself
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shutdown_o <= 1'b0;
      led_drive_en_o <= 1'b0;
      rail_reg_en_o <= 1'b0;
      reservoir_sw_o <= 1'b0;
      bias_en_o <= 1'b0;
    end else begin
      shutdown_o <= (nxt_state != FDSC_ACTIVE);
      led_drive_en_o <= (nxt_state == FDSC_ACTIVE);
      // A clear in the same cycle wins over the enable bits written with it
      rail_reg_en_o <= (nxt_state == FDSC_ACTIVE) && !clear_all && cfg1_view[FDSC_CFG1_PUMP_BIT];
      reservoir_sw_o <= (nxt_state == FDSC_ACTIVE) && !clear_all && cfg1_view[FDSC_CFG1_PRECHG_BIT];
      bias_en_o <= (nxt_state != FDSC_SHDN);
    end
  end

  // Checks on the shutdown command and its hold on the analog controls
  shdn_leds_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
    shdn_cmd_wr |=> !led_drive_en_o && shutdown_o)
    else $error("LEDs not off after shutdown write");
  leds_dark_a: assert property (@(posedge mclk) disable iff (!rst_n)
    state_ff != FDSC_ACTIVE |-> !led_drive_en_o && shutdown_o)
    else $error("LEDs enabled while shut down");
  shdn_keeps_a: assert property (@(posedge mclk) disable iff (!rst_n)
    shdn_cmd_wr |=> regs_o == $past(regs_o))
    else $error("Register changed on shutdown");
  shdn_rail_a: assert property (@(posedge mclk) disable iff (!rst_n)
    shutdown_o |-> !rail_reg_en_o && !reservoir_sw_o)
    else $error("Rail or switch active in shutdown");

  // The enables follow the stored second configuration only while active
  rail_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rail_reg_en_o == (state_ff == FDSC_ACTIVE && regs_ff[1][FDSC_CFG1_PUMP_BIT]))
    else $error("Rail regulation does not follow its enable");
  switch_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
    reservoir_sw_o == (state_ff == FDSC_ACTIVE && regs_ff[1][FDSC_CFG1_PRECHG_BIT]))
    else $error("Reservoir switch does not follow its enable");

  // Bias stays on through shutdown until the rail monitor reports the output low
  bias_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_ff == FDSC_SHDN_BIAS && !vout_below_2v && !wr_in.valid) |=> bias_en_o)
    else $error("Bias dropped early");
  bias_drop_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_ff == FDSC_SHDN_BIAS && vout_below_2v && !wr_in.valid) |=> !bias_en_o)
    else $error("Bias not released");
  bias_kept_a: assert property (@(posedge mclk) disable iff (!rst_n)
    state_ff == FDSC_SHDN_BIAS |-> bias_en_o)
    else $error("Bias off before the output fell");
  bias_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
    state_ff == FDSC_SHDN |-> !bias_en_o)
    else $error("Bias on after the output fell");
  any_data_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_in.valid && wr_in.addr == FDSC_ADDR_SHUTDOWN && wr_in.data != 8'h00) |=> shutdown_o)
    else $error("Nonzero shutdown data ignored");

  // Code widths of the narrow settings, the full byte of the first pulse width, and the clear bit
  vout_width_a: assert property (@(posedge mclk) disable iff (!rst_n) regs_ff[10][7:3] == 5'h00)
    else $error("Vout code too wide");
  rechg_width_a: assert property (@(posedge mclk) disable iff (!rst_n) regs_ff[14][7:3] == 5'h00)
    else $error("Recharge code too wide");
  flash_width_a: assert property (@(posedge mclk) disable iff (!rst_n) regs_ff[2][7:6] == 2'h0)
    else $error("Flash code too wide");
  six_bit_a: assert property (@(posedge mclk) disable iff (!rst_n)
    regs_ff[3][7:6] == 2'h0 && regs_ff[4][7:6] == 2'h0 && regs_ff[11][7:6] == 2'h0 && regs_ff[13][7:6] == 2'h0)
    else $error("Six-bit current code too wide");
  tout_width_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !regs_ff[15][7] && regs_ff[12][7:5] == 3'h0)
    else $error("Time-out or reference code too wide");
  full_byte_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_in.valid && wr_in.addr == FDSC_ADDR_WID1 && !clear_all) |=> regs_ff[7] == $past(wr_in.data))
    else $error("Width register lost bits");
  clear_all_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clear_all |=> regs_ff[3] == 8'h00 && regs_ff[1] == 8'h00)
    else $error("Clear did not reset registers");
endmodule // fdsc_decoder

`default_nettype wire

// *** fdsc_pkg.sv ***
// Package for the flash driver command decoder: register map, field widths, reset values.
// Assumes a single 125 MHz logic clock and an upstream I2C slave that delivers register writes.
`default_nettype none
package fdsc_pkg;
  localparam logic [7:0] FDSC_ADDR_SHUTDOWN = 8'h00;
  localparam logic [7:0] FDSC_ADDR_CFG0 = 8'h01;
  localparam logic [7:0] FDSC_ADDR_CFG1 = 8'h02;
  localparam logic [7:0] FDSC_ADDR_FLASH1 = 8'h03;
  localparam logic [7:0] FDSC_ADDR_FLASH2 = 8'h04;
  localparam logic [7:0] FDSC_ADDR_TORCH = 8'h06;
  localparam logic [7:0] FDSC_ADDR_DLY1 = 8'h07;
  localparam logic [7:0] FDSC_ADDR_DLY2 = 8'h08;
  localparam logic [7:0] FDSC_ADDR_WID1 = 8'h0A;
  localparam logic [7:0] FDSC_ADDR_WID2 = 8'h0B;
  localparam logic [7:0] FDSC_ADDR_PHREF = 8'h0D;
  localparam logic [7:0] FDSC_ADDR_VOUT = 8'h0F;
  localparam logic [7:0] FDSC_ADDR_IND = 8'h10;
  localparam logic [7:0] FDSC_ADDR_NTCREF = 8'h11;
  localparam logic [7:0] FDSC_ADDR_NTCBIAS = 8'h12;
  localparam logic [7:0] FDSC_ADDR_RECHG = 8'h13;
  localparam logic [7:0] FDSC_ADDR_TOUT = 8'h14;
  // Code width masks per setting
  localparam logic [7:0] FDSC_MASK3 = 8'h07;
  localparam logic [7:0] FDSC_MASK5 = 8'h1F;
  localparam logic [7:0] FDSC_MASK6 = 8'h3F;
  localparam logic [7:0] FDSC_MASK7 = 8'h7F;
  localparam logic [7:0] FDSC_MASK8 = 8'hFF;
  localparam logic [7:0] FDSC_REG_RESET = 8'h00;
  localparam int FDSC_CFG1_CLEAR_BIT = 7;
  localparam int FDSC_CFG1_PRECHG_BIT = 1;
  localparam int FDSC_CFG1_PUMP_BIT = 2;
  localparam int FDSC_NREG = 16;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } fdsc_wr_t;

  typedef enum logic [1:0] {
    FDSC_ACTIVE = 2'b00,
    FDSC_SHDN_BIAS = 2'b01,
    FDSC_SHDN = 2'b11
  } fdsc_state_t;
endpackage
`default_nettype wire

// *** fdsc_host_model.sv ***
// Host-side model: hands the decoder one completed register write at a time.
// Assumes the bench calls its tasks from one process, after reset is released.
`timescale 1ns/1ps
`default_nettype none
module fdsc_host_model
  import fdsc_pkg::*;
(
  input wire logic mclk,
  output var fdsc_wr_t wr_o
);
  initial wr_o = '0;
  // One write: register address and data byte together, valid for a single edge
  task automatic send(input logic [7:0] addr, input logic [7:0] data);
    @(posedge mclk);
    wr_o <= '{valid: 1'b1, addr: addr, data: data};
    @(posedge mclk);
    wr_o <= '{valid: 1'b0, addr: ~addr, data: ~data}; // Idle bus never repeats the last byte
  endtask
  // Shutdown as the host should send it: register zero, all-zero data
  task automatic shut_down();
    send(FDSC_ADDR_SHUTDOWN, 8'h00);
  endtask
endmodule // fdsc_host_model
`default_nettype wire

// *** fdsc_decoder_tb.sv ***
// Self-checking bench for the command decoder, driven through the host model.
// Assumes the host model file and the package are compiled first.
`timescale 1ns/1ps
`default_nettype none
module fdsc_decoder_tb;
  import fdsc_pkg::*;
  logic mclk, rst_n, vout_below_2v, shutdown_o, led_drive_en_o, rail_reg_en_o, reservoir_sw_o, bias_en_o;
  logic [127:0] regs_o, exp_regs;
  fdsc_wr_t wr;
  int bad_count, checked, cycles;
  logic [7:0] addr_tab [16] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h08, 8'h0A,
                               8'h0B, 8'h0D, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14};
  logic [7:0] mask_tab [16] = '{8'hFF, 8'hFF, 8'h3F, 8'h3F, 8'h3F, 8'hFF, 8'hFF, 8'hFF,
                               8'hFF, 8'hFF, 8'h07, 8'h3F, 8'h1F, 8'h3F, 8'h07, 8'h7F};
  fdsc_host_model host (.mclk(mclk), .wr_o(wr));
  fdsc_decoder dut (.mclk(mclk), .rst_n(rst_n), .wr_in(wr), .vout_below_2v(vout_below_2v),
    .shutdown_o(shutdown_o), .led_drive_en_o(led_drive_en_o), .rail_reg_en_o(rail_reg_en_o),
    .reservoir_sw_o(reservoir_sw_o), .bias_en_o(bias_en_o), .regs_o(regs_o));
  // Clock, 8 ns period
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // Compare one observed value with its expectation
  task automatic chk(input string name, input logic [127:0] seen, input logic [127:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Bus write followed by a settle delay so outputs are sampled after the edge
  task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
    host.send(addr, data);
    #1;
  endtask
  // Checks all five control outputs at once
  task automatic chk_ctl(input logic [4:0] exp);
    chk("controls", 128'({shutdown_o, led_drive_en_o, rail_reg_en_o, reservoir_sw_o, bias_en_o}), 128'(exp));
  endtask
  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", bad_count, checked);
    if (bad_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      end_of_test();
    end
  end
  initial begin
    rst_n = 1'b0;
    vout_below_2v = 1'b0;
    exp_regs = '0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    chk_ctl(5'b00000);
    chk("regs", regs_o, exp_regs);
    // First edge after release: LED drivers and bias come up, rail and switch stay off
    @(posedge mclk);
    #1;
    chk_ctl(5'b01001);
    // All-ones to every register; cfg1 gets 7F so the clear bit stays low
    for (int k = 0; k < 16; k++) begin
      wr_reg(addr_tab[k], (k == 1) ? 8'h7F : 8'hFF);
      exp_regs[k*8+:8] = ((k == 1) ? 8'h7F : 8'hFF) & mask_tab[k];
    end
    chk("regs", regs_o, exp_regs);
    wr_reg(8'h05, 8'h55);
    chk("regs", regs_o, exp_regs);
    chk_ctl(5'b01111);
    // Shutdown with a non-zero data byte
    wr_reg(FDSC_ADDR_SHUTDOWN, 8'hA5);
    chk_ctl(5'b10001);
    chk("regs", regs_o, exp_regs);
    @(posedge mclk);
    vout_below_2v <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk("bias", 128'(bias_en_o), 128'(1'b0));
    // Wake, then the recommended shutdown form
    wr_reg(FDSC_ADDR_CFG0, 8'h5A);
    exp_regs[7:0] = 8'h5A;
    chk_ctl(5'b01111);
    host.shut_down();
    #1;
    chk_ctl(5'b10001);
    // Monitor still reports the output low, so the bias goes one edge later
    @(posedge mclk);
    #1;
    chk_ctl(5'b10000);
    chk("regs", regs_o, exp_regs);
    // Clear bit returns every register to zero
    wr_reg(FDSC_ADDR_CFG1, 8'h80);
    chk("regs", regs_o, 128'h0);
    chk_ctl(5'b01001);
    end_of_test();
  end
endmodule // fdsc_decoder_tb
`default_nettype wire
